// File: rtl/rtcta_pkg.sv
package rtcta_pkg;
   // register window of the timekeeping slave, 0x00 to 0x0F
   localparam logic [3:0] ADDR_FLAGS = 4'h0;
   localparam logic [3:0] ADDR_CLK_BASE = 4'h8;
   localparam logic [3:0] ADDR_LAST = 4'hF;
   // flags register bit positions
   localparam int FLAG_R_POS = 0;
   localparam int FLAG_W_POS = 1;
   // clock field indexes, register address is ADDR_CLK_BASE plus index
   localparam int NUM_CLK = 8;
   localparam int F_SEC = 0;
   localparam int F_MIN = 1;
   localparam int F_HR = 2;
   localparam int F_DAY = 3;
   localparam int F_DATE = 4;
   localparam int F_MON = 5;
   localparam int F_YR = 6;
   localparam int F_CEN = 7;
   // writable bits per field, everything else reads as zero
   localparam logic [7:0][7:0] CLK_MASK = {8'hFF, 8'hFF, 8'h1F, 8'h3F,
                                          8'h07, 8'h3F, 8'h7F, 8'h7F};
   // last value of each field before it wraps (date is computed)
   localparam logic [7:0][7:0] CLK_MAX = {8'h99, 8'h99, 8'h12, 8'h31,
                                         8'h07, 8'h23, 8'h59, 8'h59};
   // value each field wraps to
   localparam logic [7:0][7:0] CLK_MIN = {8'h00, 8'h00, 8'h01, 8'h01,
                                         8'h01, 8'h00, 8'h00, 8'h00};
   // reset value of the running time: 2000-01-01, day 1, 00:00:00
   localparam logic [7:0][7:0] CLK_RST = {8'h20, 8'h00, 8'h01, 8'h01,
                                         8'h01, 8'h00, 8'h00, 8'h00};
   // user copy refresh bound after a read transaction ends
   localparam int CLK_MHZ = 125;
   localparam int REFRESH_MS = 20;
   localparam int REFRESH_CYC = REFRESH_MS * 1000 * CLK_MHZ;
endpackage : rtcta_pkg

// File: rtl/rtcta_sync.sv
// three-stage synchroniser; output level changes once stages two and three agree
module rtcta_sync
   import rtcta_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_async,
   output logic o_level
);
   typedef struct packed {
      logic s1;  // metastable stage, read only by s2
      logic s2;
      logic s3;
      logic lvl; // filtered level
   } rtcta_sync_st_t;

   rtcta_sync_st_t st_q;
   rtcta_sync_st_t st_d;

   // shift and accept a level only when the settled stages agree
   always_comb begin
      st_d = st_q;
      st_d.s1 = i_async;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      if (st_q.s2 == st_q.s3) begin
         st_d.lvl = st_q.s3;
      end
   end

   // register the whole state
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_level = st_q.lvl;
endmodule : rtcta_sync

// File: rtl/rtcta_bcd_inc.sv
// one bcd field step: wraps at max, bad nibbles run on to F then 0
module rtcta_bcd_inc
   import rtcta_pkg::*;
(
   input wire logic [7:0] i_val,
   input wire logic [7:0] i_max,
   input wire logic [7:0] i_min,
   output logic [7:0] o_next,
   output logic o_wrap
);
   logic lo_carry; // low nibble rolls into high nibble

   // bcd increment with rollover of non-decimal nibbles
   always_comb begin
      lo_carry = (i_val[3:0] == 4'h9) || (i_val[3:0] == 4'hF);
      o_wrap = (i_val == i_max);
      if (o_wrap) begin
         o_next = i_min;
      end else if (lo_carry) begin
         o_next = {i_val[7:4] + 4'h1, 4'h0};
      end else begin
         o_next = {i_val[7:4], i_val[3:0] + 4'h1};
      end
   end
endmodule : rtcta_bcd_inc

// File: rtl/rtcta_core.sv
module rtcta_core
   import rtcta_pkg::*;
#(
   parameter int P_REFRESH_CYC = REFRESH_CYC // bound on user copy refresh
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_osc_1hz,       // 1 Hz square wave from the oscillator divider
   input wire logic i_supply_low,    // primary supply below switchover_threshold
   input wire logic i_osc_fail,      // oscillator failure seen at power-up, pulse
   input wire logic i_rd_start,      // read transaction on timekeeping slave begins
   input wire logic i_bus_end,       // STOP or repeated START seen
   input wire logic i_reg_wr,        // data byte write strobe
   input wire logic i_reg_rd,        // data byte read strobe
   input wire logic [3:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,   // valid the cycle after i_reg_rd
   output logic o_backup_sel,        // timekeeping runs from backup supply
   output logic o_commit             // one-cycle pulse when new time is loaded
);
   typedef struct packed {
      logic w;                 // time write enable
      logic r;                 // snapshot hold
      logic pend;              // W cleared, waiting for bus end
      logic frz;               // read transaction in progress
      logic [7:0][7:0] usr;    // user copy seen by the bus
      logic [7:0][7:0] cnt;    // running counters
      logic [7:0][7:0] base;   // last committed base time
      logic [7:0] rdata;
      logic bkp;
      logic tick_lvl;          // last seen 1 Hz level
      logic commit;
   } rtcta_st_t;

   rtcta_st_t st_q;
   rtcta_st_t st_d;

   logic sec_lvl;                 // synchronised 1 Hz level
   logic supply_low;              // synchronised supply comparator
   logic [7:0][7:0] nxt;          // incremented value per field
   logic [7:0] wrap;              // field is at its last value
   logic [7:0] step;              // field advances this cycle
   logic [7:0][7:0] fmax;         // per-field wrap point
   logic [7:0] dim;               // days in current month, bcd
   logic [2:0] yr_mod;            // year parity sum for leap test
   logic [2:0] cen_mod;
   logic leap;
   logic hold;                    // user copy must not follow counters
   logic tick;
   logic [3:0] fidx;              // field index of addressed clock register
   logic is_clk;

   // both async sources pass the three-stage filter; a glitch shorter than
   // one clock cycle never reaches the counters or the supply select
   rtcta_sync u_sync_sec (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_async(i_osc_1hz),
      .o_level(sec_lvl)
   );

   rtcta_sync u_sync_supply (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_async(i_supply_low),
      .o_level(supply_low)
   );

   // month length and leap year; a mod-4 test on bcd uses tens parity
   always_comb begin
      yr_mod = {2'b00, st_q.cnt[F_YR][4]} * 3'd2 + {1'b0, st_q.cnt[F_YR][1:0]};
      cen_mod = {2'b00, st_q.cnt[F_CEN][4]} * 3'd2 + {1'b0, st_q.cnt[F_CEN][1:0]};
      if (st_q.cnt[F_YR] == 8'h00) begin
         leap = (cen_mod[1:0] == 2'b00);
      end else begin
         leap = (yr_mod[1:0] == 2'b00);
      end
      unique case (st_q.cnt[F_MON])
         8'h02: dim = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
         default: dim = 8'h31;
      endcase
      fmax = CLK_MAX;
      fmax[F_DATE] = dim;
   end

   // one incrementer per field
   // trade-off: eight small adders, so a full carry settles in one cycle
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CLK; gi++) begin : g_fld
         rtcta_bcd_inc u_inc (
            .i_val(st_q.cnt[gi]),
            .i_max(fmax[gi]),
            .i_min(CLK_MIN[gi]),
            .o_next(nxt[gi]),
            .o_wrap(wrap[gi])
         );
      end
   endgenerate

   // carry chain: seconds to hours, then weekday and date in parallel
   always_comb begin
      tick = sec_lvl && !st_q.tick_lvl;
      step[F_SEC] = tick;
      step[F_MIN] = step[F_SEC] && wrap[F_SEC];
      step[F_HR] = step[F_MIN] && wrap[F_MIN];
      step[F_DAY] = step[F_HR] && wrap[F_HR];
      step[F_DATE] = step[F_HR] && wrap[F_HR];
      step[F_MON] = step[F_DATE] && wrap[F_DATE];
      step[F_YR] = step[F_MON] && wrap[F_MON];
      step[F_CEN] = step[F_YR] && wrap[F_YR];
   end

   // address decode; the whole 4-bit space belongs to this slave
   // hold comes from registered flags, so the cycle that sets one still refreshes
   always_comb begin
      is_clk = (i_reg_addr >= ADDR_CLK_BASE);
      fidx = i_reg_addr - ADDR_CLK_BASE;
      hold = st_q.r || st_q.frz || st_q.w || st_q.pend;
   end

   // next state of the timekeeping core
   always_comb begin
      st_d = st_q;
      st_d.commit = 1'b0;
      st_d.tick_lvl = sec_lvl;
      st_d.bkp = supply_low;
      // running counters keep counting whatever the user copy does
      for (int i = 0; i < NUM_CLK; i++) begin
         if (step[i]) begin
            st_d.cnt[i] = nxt[i];
         end
      end
      // user copy follows counters unless held; refresh is next cycle
      if (!hold) begin
         st_d.usr = st_q.cnt;
      end
      // read port, unused bits come back zero
      if (i_reg_rd) begin
         if (i_reg_addr == ADDR_FLAGS) begin
            st_d.rdata = {6'h00, st_q.w, st_q.r};
         end else if (is_clk) begin
            st_d.rdata = st_q.usr[fidx[2:0]] & CLK_MASK[fidx[2:0]];
         end else begin
            st_d.rdata = 8'h00;
         end
      end
      // register writes
      if (i_reg_wr) begin
         if (i_reg_addr == ADDR_FLAGS) begin
            st_d.r = i_reg_wdata[FLAG_R_POS];
            st_d.w = i_reg_wdata[FLAG_W_POS];
            if (st_q.w && !i_reg_wdata[FLAG_W_POS]) begin
               st_d.pend = 1'b1;
            end
         end else if (is_clk && st_q.w) begin
            // staged only while W is set; master supplies 24-hour bcd
            st_d.usr[fidx[2:0]] = i_reg_wdata & CLK_MASK[fidx[2:0]];
         end
      end
      // read freeze lasts until the bus ends; a new start wins over the end
      if (i_rd_start) begin
         st_d.frz = 1'b1;
      end else if (i_bus_end) begin
         st_d.frz = 1'b0;
      end
      // commit on bus end only; without it the staged time is never used
      // a tick in the commit cycle is dropped on purpose: the new base wins
      if (i_bus_end && st_q.pend) begin
         st_d.cnt = st_q.usr;
         st_d.base = st_q.usr;
         st_d.pend = 1'b0;
         st_d.commit = 1'b1;
      end else if (i_osc_fail) begin
         // oscillator loss restarts from the stored base time
         st_d.cnt = st_q.base;
      end
   end

   // register the whole state
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= '0;
         st_q.usr <= CLK_RST;
         st_q.cnt <= CLK_RST;
         st_q.base <= CLK_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_reg_rdata = st_q.rdata;
   assign o_backup_sel = st_q.bkp;
   assign o_commit = st_q.commit;

   // helper: cycles the user copy has lagged while free to refresh
   // limitation: bounds only how late the copy lands, not which value it takes
   logic [31:0] lag_q;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lag_q <= 32'h0;
      end else if (hold || st_q.usr == st_q.cnt) begin
         lag_q <= 32'h0;
      end else begin
         lag_q <= lag_q + 32'h1;
      end
   end

   // checks below look at registered state one cycle after the cause
   chk_refresh_bound: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      lag_q < P_REFRESH_CYC) else $error("user copy not refreshed in time");

   chk_hold_freeze: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      st_q.r && !i_reg_wr |=> $stable(st_q.usr)) else $error("user copy moved while held");

   chk_read_freeze: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_rd_start ##1 (!i_bus_end && !i_reg_wr) |=> $stable(st_q.usr))
      else $error("user copy moved during read");

   chk_resume_refresh: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      $fell(st_q.r) && !st_q.frz && !st_q.w && !st_q.pend |=> st_q.usr == $past(st_q.cnt))
      else $error("refresh did not resume");

   chk_commit_load: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      st_q.pend && i_bus_end |=> st_q.cnt == $past(st_q.usr) && o_commit && !st_q.pend)
      else $error("staged time not committed");

   chk_no_commit: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      !i_bus_end |=> !o_commit) else $error("commit without bus end");

   chk_stage_write: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      st_q.w && i_reg_wr && is_clk |=> st_q.usr[$past(fidx[2:0])]
         == ($past(i_reg_wdata) & CLK_MASK[$past(fidx[2:0])]))
      else $error("time write not staged");

   chk_reserved_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_reg_rd && is_clk |=> (o_reg_rdata & ~CLK_MASK[$past(fidx[2:0])]) == 8'h00)
      else $error("reserved bits not zero");

   chk_sec_step: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      tick && !i_bus_end && !i_osc_fail && st_q.cnt[F_SEC] == 8'h59 |=>
         st_q.cnt[F_SEC] == 8'h00) else $error("seconds did not wrap");

   chk_bad_nibble: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      tick && !i_bus_end && !i_osc_fail && st_q.cnt[F_SEC][3:0] == 4'hE |=>
         st_q.cnt[F_SEC][3:0] == 4'hF) else $error("invalid nibble not run on");

   chk_backup_sel: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      supply_low |=> o_backup_sel) else $error("backup not selected");

   chk_bad_carry: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      tick && !i_bus_end && !i_osc_fail && st_q.cnt[F_SEC] == 8'h5F |=>
         st_q.cnt[F_SEC] == 8'h60) else $error("invalid nibble did not carry");

   chk_commit_refresh: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      o_commit && !st_q.r && !st_q.frz && !st_q.w |=> st_q.usr == $past(st_q.cnt))
      else $error("user copy not refreshed after commit");

   chk_osc_reload: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_osc_fail && !(i_bus_end && st_q.pend) |=> st_q.cnt == $past(st_q.base))
      else $error("counters not reloaded from base time");

   chk_base_keep: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      !(i_bus_end && st_q.pend) |=> $stable(st_q.base))
      else $error("base time changed without commit");

   chk_freeze_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_rd_start |=> st_q.frz)
      else $error("read start did not freeze");

   chk_pend_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      st_q.w && i_reg_wr && i_reg_addr == ADDR_FLAGS && !i_reg_wdata[FLAG_W_POS]
         && !i_bus_end |=> st_q.pend) else $error("cleared write enable not pending");

   chk_flags_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_reg_rd && i_reg_addr == ADDR_FLAGS |=> o_reg_rdata[7:2] == 6'h00)
      else $error("unused flag bits not zero");

   chk_backup_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      !supply_low |=> !o_backup_sel) else $error("backup kept after supply good");
endmodule : rtcta_core

// File: verif/rtcta_master.sv
// host side of the timekeeping slave: bus strobes, 1 Hz source, supply level
module rtcta_master (
   input wire logic i_core_clk,
   output logic o_osc_1hz,
   output logic o_supply_low,
   output logic o_osc_fail,
   output logic o_rd_start,
   output logic o_bus_end,
   output logic o_reg_wr,
   output logic o_reg_rd,
   output logic [3:0] o_reg_addr,
   output logic [7:0] o_reg_wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle levels from time zero
   initial begin
      {o_osc_1hz, o_supply_low, o_osc_fail, o_rd_start, o_bus_end} = '0;
      {o_reg_wr, o_reg_rd, o_reg_addr, o_reg_wdata} = '0;
   end
   // one byte write; data line flips once released so stale data is not trusted
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge i_core_clk);
      o_reg_wr = 1'b1;
      o_reg_addr = a;
      o_reg_wdata = d;
      @(negedge i_core_clk);
      o_reg_wr = 1'b0;
      o_reg_wdata = ~d;
   endtask : wr
   // one byte read request, data is taken by the bench monitor
   task automatic rd(input logic [3:0] a);
      @(negedge i_core_clk);
      o_reg_rd = 1'b1;
      o_reg_addr = a;
      @(negedge i_core_clk);
      o_reg_rd = 1'b0;
   endtask : rd
   // one-cycle event: 0 read start, 1 stop, 2 oscillator failure
   task automatic pulse(input int sel);
      @(negedge i_core_clk);
      if (sel == 0) o_rd_start = 1'b1;
      else if (sel == 1) o_bus_end = 1'b1;
      else o_osc_fail = 1'b1;
      @(negedge i_core_clk);
      {o_rd_start, o_bus_end, o_osc_fail} = '0;
   endtask : pulse
   // one second, shortened so the sync sees both levels
   task automatic tick();
      @(negedge i_core_clk);
      o_osc_1hz = 1'b1;
      repeat (8) @(negedge i_core_clk);
      o_osc_1hz = 1'b0;
      repeat (8) @(negedge i_core_clk);
   endtask : tick
   // primary supply comparator level, changed at a falling edge
   task automatic supply(input logic v);
      @(negedge i_core_clk);
      o_supply_low = v;
   endtask : supply
endmodule : rtcta_master

// File: verif/rtcta_core_tb.sv
module rtcta_core_tb
   import rtcta_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   typedef logic [7:0][7:0] rtcta_time_t; // index 0 is seconds
   logic i_core_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic osc, sup, ofail, rds, bend, rwr, rrd;
   logic [3:0] addr;
   logic [7:0] wdata, o_reg_rdata;
   logic o_backup_sel, o_commit;
   logic p1 = 1'b0;
   logic p2 = 1'b0;
   logic [7:0] exp_q[$]; // expected read bytes, oldest first
   int error_cnt = 0;
   int checked = 0;
   rtcta_time_t st[3], ex[3];
   logic [7:0] s;
   // 125 MHz
   initial forever #4 i_core_clk = ~i_core_clk;
   // refresh bound cut down so its check is reachable
   rtcta_core #(.P_REFRESH_CYC(16)) rtcta_core_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
      .i_osc_1hz(osc), .i_supply_low(sup), .i_osc_fail(ofail), .i_rd_start(rds),
      .i_bus_end(bend), .i_reg_wr(rwr), .i_reg_rd(rrd), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(o_reg_rdata), .o_backup_sel(o_backup_sel),
      .o_commit(o_commit));
   rtcta_master rtcta_master_i (.i_core_clk(i_core_clk), .o_osc_1hz(osc), .o_supply_low(sup),
      .o_osc_fail(ofail), .o_rd_start(rds), .o_bus_end(bend), .o_reg_wr(rwr),
      .o_reg_rd(rrd), .o_reg_addr(addr), .o_reg_wdata(wdata));
   task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : cmp8
   task automatic cmp1(input string n, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %b seen %b", n, e, g);
      end
   endtask : cmp1
   // read data lands on the strobe edge; look a cycle and a half later
   always @(posedge i_core_clk) begin
      p1 <= rrd;
      p2 <= p1;
   end
   always @(negedge i_core_clk) begin
      if (p2 === 1'b1) cmp8("rdata", exp_q.pop_front(), o_reg_rdata);
   end
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      rtcta_master_i.rd(a);
   endtask : rd
   // all eight clock bytes, unused bits must read zero
   task automatic rd_all(input rtcta_time_t e);
      for (int i = 0; i < NUM_CLK; i++) rd(4'(ADDR_CLK_BASE + i), e[i] & CLK_MASK[i]);
   endtask : rd_all
   // stage a time under W, then drop W so a stop can commit it
   task automatic set_time(input rtcta_time_t t);
      rtcta_master_i.wr(ADDR_FLAGS, 8'h02);
      for (int i = 0; i < NUM_CLK; i++) rtcta_master_i.wr(4'(ADDR_CLK_BASE + i), t[i]);
      rtcta_master_i.wr(ADDR_FLAGS, 8'h00);
   endtask : set_time
   // stage, prove nothing commits without stop, commit, then one second
   task automatic step_case(input rtcta_time_t a, input rtcta_time_t b);
      logic got;
      got = 1'b0;
      set_time(a);
      rtcta_master_i.tick();
      rd_all(a);
      rtcta_master_i.pulse(1);
      // the commit pulse already stands at the edge the stop is dropped on
      for (int i = 0; i < 4; i++) begin
         if (o_commit === 1'b1) got = 1'b1;
         @(negedge i_core_clk);
      end
      cmp1("commit", 1'b1, got);
      rd_all(a);
      rtcta_master_i.tick();
      rd_all(b);
   endtask : step_case
   task automatic end_test(input string n);
      $display("test %s done, mismatches so far %0d", n, error_cnt);
   endtask : end_test
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   // hang guard, the whole run needs well under a tenth of this
   initial begin
      #400000;
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'hF625FA5B));
      st[0] = {8'h99, 8'h99, 8'h12, 8'h31, 8'h07, 8'h23, 8'h59, 8'h59};
      ex[0] = {8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
      st[1] = {8'h20, 8'h24, 8'h02, 8'h28, 8'h03, 8'h23, 8'h59, 8'h59};
      ex[1] = {8'h20, 8'h24, 8'h02, 8'h29, 8'h04, 8'h00, 8'h00, 8'h00};
      st[2] = {8'h20, 8'h23, 8'h02, 8'h28, 8'h03, 8'h23, 8'h59, 8'h59};
      ex[2] = {8'h20, 8'h23, 8'h03, 8'h01, 8'h04, 8'h00, 8'h00, 8'h00};
      repeat (4) @(posedge i_core_clk);
      @(negedge i_core_clk);
      i_rst_n = 1'b1;
      rd_all(CLK_RST);
      rd(ADDR_FLAGS, 8'h00);
      rtcta_master_i.wr(4'h3, 8'hFF);
      rd(4'h3, 8'h00);
      rtcta_master_i.wr(4'h8, 8'h33);
      rd(4'h8, 8'h00);
      end_test("reset and map");
      // year, leap and non-leap february rollovers
      for (int k = 0; k < 3; k++) step_case(st[k], ex[k]);
      rtcta_master_i.pulse(2);
      repeat (6) @(negedge i_core_clk);
      rd_all(st[2]);
      end_test("calendar");
      s = {4'($urandom_range(5)), 4'($urandom_range(8))};
      step_case({CLK_RST[7:1], s}, {CLK_RST[7:1], s + 8'h01});
      // a bad low nibble keeps counting to F and then carries
      step_case({CLK_RST[7:1], 8'h5E}, {CLK_RST[7:1], 8'h5F});
      rtcta_master_i.tick();
      rd(4'h8, 8'h60);
      end_test("seconds");
      // read freeze holds until stop, then refresh
      rtcta_master_i.pulse(0);
      rtcta_master_i.tick();
      rd(4'h8, 8'h60);
      rtcta_master_i.pulse(1);
      repeat (20) @(negedge i_core_clk);
      rd(4'h8, 8'h61);
      // hold bit freezes the copy, the counter keeps running
      rtcta_master_i.wr(ADDR_FLAGS, 8'h01);
      rtcta_master_i.tick();
      rd(4'h8, 8'h61);
      rtcta_master_i.wr(ADDR_FLAGS, 8'h00);
      repeat (4) @(negedge i_core_clk);
      rd(4'h8, 8'h62);
      end_test("freeze");
      rtcta_master_i.supply(1'b1);
      repeat (10) @(negedge i_core_clk);
      cmp1("backup", 1'b1, o_backup_sel);
      rtcta_master_i.supply(1'b0);
      repeat (10) @(negedge i_core_clk);
      cmp1("backup", 1'b0, o_backup_sel);
      end_test("backup");
      repeat (4) @(negedge i_core_clk);
      tally_and_finish();
   end
endmodule : rtcta_core_tb
